// ===== design/scr_defs.svh
/*
  offsets, field positions, reset values and key constants of the system
  control register bank; assumes the includer wants plain macros only.
*/
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

`define SCR_OFF_VECTOR_BASE 12'h008
`define SCR_OFF_IRQ_RESET 12'h00C
`define SCR_OFF_SLEEP_CTRL 12'h010
`define SCR_OFF_SLEEP_STAT 12'h014
`define SCR_TBL_LSB 7
`define SCR_KEY_WRITE 16'h05FA
`define SCR_KEY_READ 16'hFA05
`define SCR_KEY_LSB 16
`define SCR_ENDIAN_BIT 15
`define SCR_PRIGRP_LSB 8
`define SCR_PRIGRP_RESET 3'h0
`define SCR_SYSRST_BIT 2
`define SCR_CLRACT_BIT 1
`define SCR_LOCRST_BIT 0
`define SCR_WAKE_PEND_BIT 4
`define SCR_DEEP_BIT 2
`define SCR_EXIT_SLEEP_BIT 1
`define SCR_SLEEPING_BIT 0

`endif

// ===== design/scr_pkg.sv
/*
  types of the system control register bank; assumes scr_defs.svh holds
  all numeric constants.
*/
package scr_pkg;
  // all flops of the bank in one record
  typedef struct packed {
    logic [24:0] table_base_field;
    logic [2:0] priority_group_point;
    logic system_reset_request;
    logic wake_on_pending;
    logic deep_sleep_select;
    logic sleep_after_handler;
    logic endian_big;
    logic strap_taken;
    logic [31:0] prdata;
    logic rd_pend;
    logic clear_active_pulse;
    logic local_reset_pulse;
  } scr_state_t;
endpackage

// ===== design/scr_regs.sv
/*
  system control register bank: vector base pointer, interrupt and reset
  control, sleep control and a sleeping status word, on an APB slave.
  assumes one clock, an asynchronous active-low reset, and that the core,
  reset controller and power controller act on the outputs.
*/
`include "scr_defs.svh"

module scr_regs #(
  parameter int TBL_DROP = 0,            // unimplemented top offset bits, 0..2
  parameter logic [24:0] TBL_RESET = 25'h0000000, // offset reset without inputs
  parameter bit HAS_TBL_CFG = 1'b0,      // offset reset taken from i_tbl_cfg
  parameter bit HAS_DEEP = 1'b1,         // deep sleep state implemented
  parameter bit ENDIAN_FROM_PIN = 1'b0,  // byte order sampled from i_big_endian
  parameter bit ENDIAN_FIXED = 1'b0      // fixed byte order, 1 = big
) (
  input wire logic i_clk,                // core clock
  input wire logic i_nrst,               // async reset, active low
  input wire logic i_local_nrst,         // sync local reset, active low
  input wire logic i_psel,               // apb select
  input wire logic i_penable,            // apb access phase
  input wire logic i_pwrite,             // apb write
  input wire logic [11:0] i_paddr,       // apb byte address
  input wire logic [31:0] i_pwdata,      // apb write data
  output logic o_pready,                 // apb ready
  output logic [31:0] o_prdata,          // apb read data
  output logic o_pslverr,                // apb error on unmapped address
  input wire logic [24:0] i_tbl_cfg,     // offset reset configuration
  input wire logic i_big_endian,         // byte order strap
  input wire logic i_pend_rise,          // an interrupt went inactive to pending
  input wire logic i_sleeping,           // core is asleep
  output logic [31:0] o_vector_table,    // formed vector table address
  output logic [2:0] o_priority_group,   // binary point position
  output logic o_big_endian,             // byte order in use
  output logic o_sys_reset_req,          // request for a local reset
  output logic o_clear_active,           // pulse: clear all active exceptions
  output logic o_local_reset,            // pulse: trigger a local reset
  output logic o_wake_event,             // pulse: wakeup from pending change
  output logic o_deep_sleep,             // deep sleep selected
  output logic o_sleep_on_exit           // sleep on return to base level
);
  localparam logic [24:0] TBL_MASK = 25'h1FFFFFF >> TBL_DROP;

  scr_pkg::scr_state_t st;
  scr_pkg::scr_state_t next_st;
  logic acc, wr, rd, hit_vb, hit_ir, hit_sc, hit_ss, key_ok;
  logic [31:0] rdv;

  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite;
  assign rd = acc && !i_pwrite;
  assign hit_vb = i_paddr == `SCR_OFF_VECTOR_BASE;
  assign hit_ir = i_paddr == `SCR_OFF_IRQ_RESET;
  assign hit_sc = i_paddr == `SCR_OFF_SLEEP_CTRL;
  assign hit_ss = i_paddr == `SCR_OFF_SLEEP_STAT;
  assign key_ok = i_pwdata[31:`SCR_KEY_LSB] == `SCR_KEY_WRITE;

  // read mux; reserved and write-only bits stay zero
  always_comb begin
    rdv = 32'h00000000;
    if (hit_vb) begin
      rdv[31:`SCR_TBL_LSB] = st.table_base_field;
    end else if (hit_ir) begin
      rdv[31:`SCR_KEY_LSB] = `SCR_KEY_READ;
      rdv[`SCR_ENDIAN_BIT] = st.endian_big;
      rdv[`SCR_PRIGRP_LSB +: 3] = st.priority_group_point;
      rdv[`SCR_SYSRST_BIT] = st.system_reset_request;
    end else if (hit_sc) begin
      rdv[`SCR_WAKE_PEND_BIT] = st.wake_on_pending;
      rdv[`SCR_DEEP_BIT] = st.deep_sleep_select;
      rdv[`SCR_EXIT_SLEEP_BIT] = st.sleep_after_handler;
    end else if (hit_ss) begin
      rdv[`SCR_SLEEPING_BIT] = i_sleeping;
    end
  end

  // next state of the whole bank
  always_comb begin
    next_st = st;
    next_st.clear_active_pulse = 1'b0;
    next_st.local_reset_pulse = 1'b0;
    // the strap is caught at the first edge after release, not by the reset
    if (!st.strap_taken) begin
      next_st.strap_taken = 1'b1;
      next_st.endian_big = ENDIAN_FROM_PIN ? i_big_endian : ENDIAN_FIXED;
      next_st.table_base_field = (HAS_TBL_CFG ? i_tbl_cfg : TBL_RESET) & TBL_MASK;
    end
    // a read captures its word in the first access cycle and completes in the second,
    // so the read data comes from a flop and still stands when pready is sampled high
    if (rd && !st.rd_pend) begin
      next_st.prdata = rdv;
      next_st.rd_pend = 1'b1;
    end else begin
      next_st.rd_pend = 1'b0;
    end
    if (wr && hit_vb) begin
      // dropped top bits never store, so they read back as zero
      next_st.table_base_field = i_pwdata[31:`SCR_TBL_LSB] & TBL_MASK;
    end
    if (wr && hit_ir && key_ok) begin
      next_st.priority_group_point = i_pwdata[`SCR_PRIGRP_LSB +: 3];
      next_st.system_reset_request = i_pwdata[`SCR_SYSRST_BIT];
      next_st.clear_active_pulse = i_pwdata[`SCR_CLRACT_BIT];
      next_st.local_reset_pulse = i_pwdata[`SCR_LOCRST_BIT];
    end
    if (wr && hit_sc) begin
      next_st.wake_on_pending = i_pwdata[`SCR_WAKE_PEND_BIT];
      next_st.deep_sleep_select = HAS_DEEP && i_pwdata[`SCR_DEEP_BIT];
      next_st.sleep_after_handler = i_pwdata[`SCR_EXIT_SLEEP_BIT];
    end
    // local reset reinitialises the bank and clears strap_taken, so the strap-derived bits are sampled again
    if (!i_local_nrst) begin
      next_st.system_reset_request = 1'b0;
      next_st.priority_group_point = `SCR_PRIGRP_RESET;
      next_st.wake_on_pending = 1'b0;
      next_st.deep_sleep_select = 1'b0;
      next_st.sleep_after_handler = 1'b0;
      next_st.clear_active_pulse = 1'b0;
      next_st.local_reset_pulse = 1'b0;
      next_st.strap_taken = 1'b0;
    end
  end

  // one register for all state; power-on reset loads constants only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
      st.priority_group_point <= `SCR_PRIGRP_RESET;
    end else begin
      st <= next_st;
    end
  end

  // writes complete in their first access cycle, reads take one wait state
  assign o_pready = !rd || st.rd_pend;
  assign o_pslverr = acc && !(hit_vb || hit_ir || hit_ss || hit_sc);
  assign o_prdata = st.prdata;
  assign o_vector_table = {st.table_base_field, 7'h00};
  assign o_priority_group = st.priority_group_point;
  assign o_big_endian = st.endian_big;
  assign o_sys_reset_req = st.system_reset_request;
  assign o_clear_active = st.clear_active_pulse;
  assign o_local_reset = st.local_reset_pulse;
  assign o_wake_event = st.wake_on_pending && i_pend_rise;
  assign o_deep_sleep = st.deep_sleep_select;
  assign o_sleep_on_exit = st.sleep_after_handler;

  // checks
  key_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (wr && hit_ir && !key_ok && i_local_nrst)
      |=> $stable(st.priority_group_point) && $stable(o_sys_reset_req))
    else $error("keyless control write changed state");
  sysreq_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (wr && hit_ir && key_ok && i_pwdata[2] && i_local_nrst) |=> o_sys_reset_req)
    else $error("reset request not raised");
  sysreq_clr_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_local_nrst |=> !o_sys_reset_req)
    else $error("reset request survived local reset");
  locrst_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_local_reset |=> !o_local_reset)
    else $error("local reset did not self clear");
  clract_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (wr && hit_ir && key_ok && i_pwdata[1] && i_local_nrst) |=> o_clear_active ##1 !o_clear_active)
    else $error("clear active pulse wrong");
  key_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (rd && hit_ir) |=> o_prdata[31:16] == 16'hFA05)
    else $error("key readback wrong");
  tbl_mask_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_vector_table[31:7] & ~TBL_MASK) == 25'h0000000 && o_vector_table[6:0] == 7'h00)
    else $error("unimplemented table bits set");
  wake_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_wake_event == (i_pend_rise && o_sleep_on_exit == st.sleep_after_handler && st.wake_on_pending))
    else $error("wake event gating wrong");
  deep_absent_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !HAS_DEEP |-> !o_deep_sleep)
    else $error("deep sleep set without deep state");
  rsvd_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (rd && hit_sc) |=> o_prdata[31:5] == 27'h0000000 && !o_prdata[0] && !o_prdata[3])
    else $error("reserved bits read nonzero");
  cov_key_write_c: cover property (@(posedge i_clk) wr && hit_ir && key_ok);
  cov_bad_key_c: cover property (@(posedge i_clk) wr && hit_ir && !key_ok);
  cov_wake_c: cover property (@(posedge i_clk) o_wake_event);
  cov_vb_ones_c: cover property (@(posedge i_clk) wr && hit_vb && (&i_pwdata[31:7]));
endmodule

// ===== tb/scr_partner.sv
/*
  far-side model: a reset controller that answers a reset request or a
  local reset pulse with a one-cycle local reset; assumes one clock.
*/
module scr_partner (
  input wire logic i_clk,        // core clock
  input wire logic i_nrst,       // async reset, active low
  input wire logic i_sys_req,    // level reset request
  input wire logic i_loc_pulse,  // local reset trigger pulse
  output logic o_local_nrst      // local reset, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt;
  // waits a few cycles like a real controller; no new trigger while in reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 3'h0;
      o_local_nrst <= 1'b1;
    end else if (cnt == 3'h1) begin
      cnt <= 3'h0;
      o_local_nrst <= 1'b0;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end else begin
      o_local_nrst <= 1'b1;
      if (o_local_nrst && (i_sys_req || i_loc_pulse)) cnt <= 3'h4;
    end
  end
endmodule

// ===== tb/tb.sv
/*
  bench: apb master, reference values and checks for the register bank;
  assumes scr_partner acts as the reset controller.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [24:0] MSK = 25'h0FFFFFF;  // one top offset bit dropped
  logic i_clk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, d, r, exp_tbl;
  logic [24:0] i_tbl_cfg = 25'h0;
  logic i_big_endian = 1'b1, i_pend_rise = 1'b0, i_sleeping = 1'b0, i_local_nrst, e;
  logic o_pready, o_pslverr, o_big_endian, o_sys_reset_req, o_clear_active, o_local_reset;
  logic o_wake_event, o_deep_sleep, o_sleep_on_exit;
  logic [31:0] o_vector_table;
  logic [2:0] o_priority_group;
  int errors = 0, cmp_count = 0, n_clr = 0, n_loc = 0, n0, seed;
  always #2.5 i_clk = ~i_clk;
  // pulses last one cycle, so they are counted rather than sampled
  always @(posedge i_clk) begin
    n_clr <= n_clr + o_clear_active;
    n_loc <= n_loc + o_local_reset;
  end
  scr_regs #(.TBL_DROP(1), .HAS_TBL_CFG(1'b1), .ENDIAN_FROM_PIN(1'b1)) dut_u (.*);
  scr_partner part_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_sys_req(o_sys_reset_req),
    .i_loc_pulse(o_local_reset), .o_local_nrst(i_local_nrst));
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one apb transfer; read data and error are taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      give_verdict();
    end
    e = o_pslverr;
    r = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(r, exp);
  endtask
  // the partner answers within a few cycles; give up after twenty
  task automatic wait_lrst();
    int n;
    n = 0;
    while (i_local_nrst !== 1'b0 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20) begin
      errors++;
      give_verdict();
    end
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  initial begin
    seed = 32'h70fd;
    i_tbl_cfg = $random(seed);
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    exp_tbl = {i_tbl_cfg & MSK, 7'h00};
    rd_chk(12'h008, exp_tbl);
    chk32(o_vector_table, exp_tbl);
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    rd_chk(12'h008, {MSK, 7'h00});
    rd_chk(12'h00C, 32'hFA058000);
    chk32(o_big_endian, 1'b1);
    for (int g = 0; g < 8; g++) begin
      apb(1'b1, 12'h00C, 32'h05FA0000 | (g << 8));
      d = $random(seed) & 32'hFFFF0704;
      if (d[31:16] == 16'h05FA) d[31:16] = 16'h0000;
      apb(1'b1, 12'h00C, d);
      rd_chk(12'h00C, 32'hFA058000 | (g << 8));
      chk32({o_sys_reset_req, o_priority_group}, g);
    end
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      apb(1'b1, 12'h010, d);
      rd_chk(12'h010, d & 32'h16);
      chk32({o_deep_sleep, o_sleep_on_exit}, d[2:1]);
      @(posedge i_clk);
      i_pend_rise <= 1'b1;
      #1;
      chk32(o_wake_event, d[4]);
      @(posedge i_clk);
      i_pend_rise <= 1'b0;
      i_sleeping <= d[7];
      rd_chk(12'h014, d[7]);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk32(e, 1'b1);
    // the bench stands in for a debugger with the core halted
    n0 = n_clr;
    apb(1'b1, 12'h00C, 32'h05FA0302);
    chk32(n_clr - n0, 1);
    rd_chk(12'h00C, 32'hFA058300);
    apb(1'b1, 12'h010, 32'h00000016);
    n0 = n_loc;
    apb(1'b1, 12'h00C, 32'h05FA0301);
    chk32(n_loc - n0, 1);
    wait_lrst();
    rd_chk(12'h00C, 32'hFA058000);
    rd_chk(12'h008, exp_tbl);
    apb(1'b1, 12'h00C, 32'h05FA0004);
    chk32(o_sys_reset_req, 1'b1);
    wait_lrst();
    chk32(o_sys_reset_req, 1'b0);
    give_verdict();
  end
endmodule
